// ---- test/dual_timer_bench.sv ----
// Self-checking bench for the dual timer: bus, counting modes, gating and interrupt detect.
`timescale 1ns/1ps
`include "dual_timer_map.vh"
module dual_timer_bench;
	reg mclk = 1'b0;
	reg rst = 1'b1;
	reg [11:0] s_axi_awaddr = 12'h000;
	reg [11:0] s_axi_araddr = 12'h000;
	reg [31:0] s_axi_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg s_axi_awvalid = 1'b0;
	reg s_axi_wvalid = 1'b0;
	reg s_axi_arvalid = 1'b0;
	reg s_axi_bready = 1'b1;
	reg s_axi_rready = 1'b1;
	reg [3:0] ack = 4'h0;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire extIrq0Pin, extIrq1Pin, t0CountPin, t1CountPin;
	wire t0OverflowFlag, t1OverflowFlag, extIrq0DetectFlag, extIrq1DetectFlag, irq;
	integer fail_count = 0;
	integer total_checks = 0;
	integer m, t, k, x;
	reg [7:0] hi, lo;
	reg [16:0] e;
	reg [31:0] rq;
	reg [1:0] rr;
	always #4 mclk = ~mclk;
	dual_timer dual_timer_i (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .extIrq0Pin, .extIrq1Pin, .t0CountPin,
		.t1CountPin, .t0VecAck(ack[0]), .t1VecAck(ack[1]), .ext0VecAck(ack[2]),
		.ext1VecAck(ack[3]), .t0OverflowFlag, .t1OverflowFlag, .extIrq0DetectFlag,
		.extIrq1DetectFlag, .irq);
	pin_driver_model pin_driver_model_i (.mclk, .extIrq0Pin, .extIrq1Pin, .t0CountPin,
		.t1CountPin);
	task results;
		begin
			$display("checks %0d mismatches %0d", total_checks, fail_count);
			if (fail_count == 0 && total_checks > 0) begin
				$display("TEST PASSED");
			end else begin
				$display("TEST FAILED");
			end
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] ex, input [31:0] got);
		begin
			total_checks = total_checks + 1;
			if (got !== ex) begin
				fail_count = fail_count + 1;
				$display("Error %s expected %h seen %h", nm, ex, got);
			end
		end
	endtask
	// Ready is read at the falling edge, so it is the value the next rising edge samples.
	task xfer(input w, input [7:0] idx, input [7:0] d);
		integer n;
		reg ta, tw, tr;
		begin
			@(posedge mclk);
			if (w) begin
				s_axi_awaddr <= {2'b00, idx, 2'b00};
				s_axi_wdata <= {24'h0, d};
				s_axi_awvalid <= 1'b1;
				s_axi_wvalid <= 1'b1;
			end else begin
				s_axi_araddr <= {2'b00, idx, 2'b00};
				s_axi_arvalid <= 1'b1;
			end
			tr = 1'b0;
			for (n = 0; n < 50 && !tr; n = n + 1) begin
				@(negedge mclk);
				ta = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
				tw = s_axi_wvalid && s_axi_wready;
				tr = w ? s_axi_bvalid : s_axi_rvalid;
				rq = s_axi_rdata;
				rr = w ? s_axi_bresp : s_axi_rresp;
				@(posedge mclk);
				if (ta && w) s_axi_awvalid <= 1'b0;
				if (ta && !w) s_axi_arvalid <= 1'b0;
				if (tw) s_axi_wvalid <= 1'b0;
			end
			if (!tr) chk("bus answer", 1, 0);
		end
	endtask
	task wr(input [7:0] idx, input [7:0] d);
		xfer(1'b1, idx, d);
	endtask
	task rdchk(input string nm, input [7:0] idx, input [31:0] ex);
		begin
			xfer(1'b0, idx, 8'h00);
			chk(nm, ex, rq);
		end
	endtask
	task vec(input integer i);
		begin
			@(posedge mclk);
			ack[i] <= 1'b1;
			@(posedge mclk);
			ack[i] <= 1'b0;
			@(negedge mclk);
		end
	endtask
	function det(input integer i);
		det = i ? extIrq1DetectFlag : extIrq0DetectFlag;
	endfunction
	function [16:0] expect_count(input [1:0] md, input [7:0] h, input [7:0] l, input integer n);
		reg o;
		integer j;
		begin
			o = 1'b0;
			for (j = 0; j < n; j = j + 1) begin
				case (md)
					2'h0: begin
						if (l[4:0] == 5'h1f) begin
							o = o | (h == 8'hff);
							h = h + 8'h01;
						end
						l[4:0] = l[4:0] + 5'h01;
					end
					2'h1: begin
						o = o | ({h, l} == 16'hffff);
						{h, l} = {h, l} + 16'h0001;
					end
					default: begin
						o = o | (l == 8'hff);
						l = (l == 8'hff) ? h : l + 8'h01;
					end
				endcase
			end
			expect_count = {o, h, l};
		end
	endfunction
	initial begin
		repeat (30000) @(posedge mclk);
		fail_count = fail_count + 1;
		$display("Error watchdog expected done seen hang");
		results;
	end
	initial begin
		k = $urandom(28);
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rdchk("control", `IDX_CONTROL, `RST_CONTROL);
		rdchk("mode", `IDX_MODE, `RST_MODE);
		rdchk("clock select", `IDX_CLKSEL, `RST_CLKSEL);
		rdchk("irq enable", `IDX_IRQ_EN, `RST_IRQ);
		wr(8'h40, 8'h55);
		chk("unmapped write", `RESP_SLVERR, rr);
		rdchk("unmapped read", 8'h40, 0);
		chk("unmapped read resp", `RESP_SLVERR, rr);
		for (m = 0; m < 3; m = m + 1) begin
			for (t = 0; t < 2; t = t + 1) begin
				lo = 8'hfc | 8'($urandom % 4);
				hi = ($urandom % 2) ? 8'hff : 8'($urandom);
				k = 1 + $urandom % 4;
				wr(`IDX_CONTROL, 8'h00);
				wr(`IDX_MODE, 8'((4 | m) << (4 * t)));
				wr(8'(`IDX_LOW0 + t), lo);
				wr(8'(`IDX_HIGH0 + t), hi);
				wr(`IDX_CONTROL, t ? 8'h40 : 8'h10);
				repeat (k) pin_driver_model_i.fall(2 + t, 4 + $urandom % 8);
				e = expect_count(m[1:0], hi, lo, k);
				xfer(1'b0, 8'(`IDX_LOW0 + t), 8'h00);
				chk("low count", m ? e[7:0] : e[4:0], m ? rq : rq[4:0]);
				rdchk("high count", 8'(`IDX_HIGH0 + t), e[15:8]);
				xfer(1'b0, `IDX_CONTROL, 8'h00);
				chk("overflow flag", e[16], rq[t ? 7 : 5]);
			end
		end
		wr(`IDX_MODE, 8'h0d);
		wr(`IDX_LOW0, 8'h00);
		wr(`IDX_CONTROL, 8'h00);
		pin_driver_model_i.fall(2, 5);
		rdchk("halted count", `IDX_LOW0, 0);
		wr(`IDX_CONTROL, 8'h10);
		pin_driver_model_i.level(0, 1'b0);
		pin_driver_model_i.fall(2, 5);
		rdchk("gated count", `IDX_LOW0, 0);
		pin_driver_model_i.level(0, 1'b1);
		pin_driver_model_i.fall(2, 5);
		rdchk("enabled count", `IDX_LOW0, 1);
		wr(`IDX_MODE, 8'h70);
		wr(`IDX_LOW1, 8'h05);
		wr(`IDX_CONTROL, 8'h40);
		pin_driver_model_i.fall(3, 5);
		rdchk("held timer 1", `IDX_LOW1, 8'h05);
		wr(`IDX_CONTROL, 8'h00);
		wr(`IDX_IRQ_CLR, 8'h0f);
		wr(`IDX_MODE, 8'h37);
		wr(`IDX_CLKSEL, 8'h10);
		wr(`IDX_LOW0, 8'h10);
		wr(`IDX_HIGH0, 8'hfe);
		wr(`IDX_CONTROL, 8'h50);
		repeat (3) pin_driver_model_i.fall(2, 5);
		@(negedge mclk);
		chk("split high overflow", 1, t1OverflowFlag);
		chk("split low flag", 0, t0OverflowFlag);
		rdchk("split low count", `IDX_LOW0, 8'h13);
		wr(`IDX_CONTROL, 8'h80);
		chk("write resp", `RESP_OKAY, rr);
		wr(`IDX_IRQ_EN, 8'h00);
		@(negedge mclk);
		chk("masked irq", 0, irq);
		wr(`IDX_IRQ_EN, 8'h02);
		@(negedge mclk);
		chk("enabled irq", 1, irq);
		wr(`IDX_IRQ_CLR, 8'h02);
		@(negedge mclk);
		chk("cleared irq", 0, irq);
		rdchk("clear reads zero", `IDX_IRQ_CLR, 0);
		wr(`IDX_CONTROL, 8'ha0);
		vec(0);
		chk("t0 flag vectored", 0, t0OverflowFlag);
		chk("t1 flag kept", 1, t1OverflowFlag);
		vec(1);
		chk("t1 flag vectored", 0, t1OverflowFlag);
		// The divider runs free, so the window admits up to two ticks of phase above the nominal count.
		for (k = 0; k < 2; k = k + 1) begin
			wr(`IDX_MODE, 8'h01);
			wr(`IDX_CLKSEL, k ? 8'h08 : 8'h00);
			wr(`IDX_LOW0, 8'h00);
			wr(`IDX_CONTROL, 8'h10);
			repeat (96) @(posedge mclk);
			wr(`IDX_CONTROL, 8'h00);
			xfer(1'b0, `IDX_LOW0, 8'h00);
			e = 96 / (k ? `DIV_FAST : `DIV_SLOW);
			chk("tick rate", 1, rq >= e && rq <= e + 2);
		end
		for (x = 0; x < 2; x = x + 1) begin
			wr(`IDX_CONTROL, x ? 8'h04 : 8'h01);
			pin_driver_model_i.fall(x, 5);
			@(negedge mclk);
			chk("edge detect", 1, det(x));
			vec(2 + x);
			chk("edge vectored", 0, det(x));
			wr(`IDX_CONTROL, 8'h00);
			pin_driver_model_i.level(x, 1'b0);
			@(negedge mclk);
			chk("level detect", 1, det(x));
			pin_driver_model_i.level(x, 1'b1);
			@(negedge mclk);
			chk("level release", 0, det(x));
		end
		results;
	end
endmodule // dual_timer_bench

bind dual_timer dual_timer_monitor dual_timer_monitor_i (.mclk, .rst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.t0VecAck, .t1VecAck, .t0OverflowFlag, .t1OverflowFlag);

// ---- test/dual_timer_monitor.sv ----
// Checker for the dual timer bus handshakes and overflow flag clearing.
`timescale 1ns/1ps
module dual_timer_monitor (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Bus handshakes
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// Vector acknowledge and flags
	input wire t0VecAck,
	input wire t1VecAck,
	input wire t0OverflowFlag,
	input wire t1OverflowFlag
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// The bench only acknowledges with both timers halted, so no overflow can win the race.
	property p_clr0; t0VecAck && t0OverflowFlag |=> !t0OverflowFlag; endproperty
	property p_clr1; t1VecAck && t1OverflowFlag |=> !t1OverflowFlag; endproperty
	property p_bafter; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 $rose(s_axi_bvalid); endproperty
	property p_rafter; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 1'b1; endproperty
	property p_arblock; s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_rdhi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	a_clr0: assert property (p_clr0) else $error("timer 0 flag kept after vector");
	a_clr1: assert property (p_clr1) else $error("timer 1 flag kept after vector");
	a_bafter: assert property (p_bafter) else $error("write response late");
	a_rafter: assert property (p_rafter) else $error("read data late");
	a_bdone: assert property (p_bdone) else $error("write response not released");
	a_rdone: assert property (p_rdone) else $error("read data not released");
	a_arblock: assert property (p_arblock) else $error("read address taken while busy");
	a_rdhi: assert property (p_rdhi) else $error("upper read data not zero");
	c_write: cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
	c_read: cover property (s_axi_arvalid && s_axi_arready);
	c_vec: cover property (t1VecAck && t1OverflowFlag);
endmodule // dual_timer_monitor

// ---- test/pin_driver_model.sv ----
// Model of the pins around the timer: interrupt and count inputs, all pulled high.
`timescale 1ns/1ps
module pin_driver_model (
	// Clock
	input wire mclk,
	// Pins
	output wire extIrq0Pin,
	output wire extIrq1Pin,
	output wire t0CountPin,
	output wire t1CountPin
);
	// Index 0 and 1 are the interrupt pins, 2 and 3 the count pins.
	reg [3:0] pinLevel = 4'hf;
	assign extIrq0Pin = pinLevel[0];
	assign extIrq1Pin = pinLevel[1];
	assign t0CountPin = pinLevel[2];
	assign t1CountPin = pinLevel[3];
	// Phases shorter than two cycles would be swallowed by the input filter.
	task fall(input integer k, input integer w);
		begin
			@(posedge mclk);
			pinLevel[k] <= 1'b0;
			repeat (w) @(posedge mclk);
			pinLevel[k] <= 1'b1;
			repeat (w) @(posedge mclk);
		end
	endtask
	task level(input integer k, input reg v);
		begin
			@(posedge mclk);
			pinLevel[k] <= v;
			repeat (8) @(posedge mclk);
		end
	endtask
endmodule // pin_driver_model

// ---- verilog/dual_timer.v ----
// Dual 16-bit timer/counter with external interrupt detection and an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "dual_timer_map.vh"
module dual_timer #(
	parameter AW = 12
) (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// AXI4-Lite write address and data
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// External pins
	input wire extIrq0Pin,
	input wire extIrq1Pin,
	input wire t0CountPin,
	input wire t1CountPin,
	// Service routine entry from the interrupt controller
	input wire t0VecAck,
	input wire t1VecAck,
	input wire ext0VecAck,
	input wire ext1VecAck,
	// Flags and interrupt
	output wire t0OverflowFlag,
	output wire t1OverflowFlag,
	output wire extIrq0DetectFlag,
	output wire extIrq1DetectFlag,
	output wire irq
);
	reg [7:0] control_r, mode_r, low0_r, high0_r, low1_r, high1_r;
	reg [7:0] wData_r, rdVal, control_nxt, high0Split;
	reg [1:0] clkSel_r;
	reg [3:0] irqStat_r, irqEn_r;
	reg [AW-1:0] awAddr_r;
	reg [16:0] step0, step1;
	reg awHeld_r, wHeld_r, wLane0_r, rdHit, high0Ovf;
	wire int0Level, int0Fell, int1Level, int1Fell;
	wire cnt0Fell, cnt1Fell, tick0, tick1;
	wire [3:0] modeT0, modeT1, irqEvent;
	wire run0, run1, inc0, inc1, incHigh0, split0, doWrite, wrEn;
	wire [7:0] wrIdx;

	// One count step of a timer in the given mode; bit 16 is the overflow.
	function [16:0] stepTimer;
		input [1:0] opMode;
		input [7:0] lo;
		input [7:0] hi;
		input inc;
		reg [16:0] wide;
		begin
			wide = {1'b0, hi, lo} + 17'h00001;
			stepTimer = {1'b0, hi, lo};
			if (inc) begin
				case (opMode)
					`OPMODE_PRESCALE: begin
						if (lo[4:0] == 5'h1f) begin
							stepTimer = {(hi == 8'hff), hi + 8'h01, lo[7:5], 5'h00};
						end else begin
							stepTimer = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
						end
					end
					`OPMODE_FULL: begin
						stepTimer = wide;
					end
					`OPMODE_RELOAD: begin
						if (lo == 8'hff) begin
							stepTimer = {1'b1, hi, hi};
						end else begin
							stepTimer = {1'b0, hi, lo + 8'h01};
						end
					end
					default: begin
						stepTimer = {(lo == 8'hff), hi, lo + 8'h01};
					end
				endcase
			end
		end
	endfunction

	// Register index from a byte address; the two low bits are ignored.
	function [7:0] regIndex;
		input [AW-1:0] addr;
		begin
			regIndex = addr[9:2];
		end
	endfunction

	// Pin synchronisers.
	pin_sync syncInt0 (
		.mclk(mclk),
		.rst(rst),
		.pinIn(extIrq0Pin),
		.level_r(int0Level),
		.fell_r(int0Fell)
	);
	pin_sync syncInt1 (
		.mclk(mclk),
		.rst(rst),
		.pinIn(extIrq1Pin),
		.level_r(int1Level),
		.fell_r(int1Fell)
	);
	pin_sync syncCnt0 (
		.mclk(mclk),
		.rst(rst),
		.pinIn(t0CountPin),
		.level_r(),
		.fell_r(cnt0Fell)
	);
	pin_sync syncCnt1 (
		.mclk(mclk),
		.rst(rst),
		.pinIn(t1CountPin),
		.level_r(),
		.fell_r(cnt1Fell)
	);

	// Internal tick per timer.
	tick_div div0 (
		.mclk(mclk),
		.rst(rst),
		.divFast(clkSel_r[0]),
		.tick_r(tick0)
	);
	tick_div div1 (
		.mclk(mclk),
		.rst(rst),
		.divFast(clkSel_r[1]),
		.tick_r(tick1)
	);

	assign modeT0 = mode_r[3:0];
	assign modeT1 = mode_r[7:4];
	assign split0 = (modeT0[1:0] == `OPMODE_SPLIT);

	// Enable is run bit, optionally gated by the interrupt pin being high.
	assign run0 = control_r[`CTL_T0_RUN] & (~modeT0[`MODE_GATE] | int0Level);
	assign run1 = control_r[`CTL_T1_RUN] & (~modeT1[`MODE_GATE] | int1Level);
	assign inc0 = run0 & (modeT0[`MODE_SRC] ? cnt0Fell : tick0);
	// Timer 1 parks in the split mode and keeps its count.
	assign inc1 = run1 & (modeT1[1:0] != `OPMODE_SPLIT) &
		(modeT1[`MODE_SRC] ? cnt1Fell : tick1);
	// Split high byte is a plain timer on timer 1's run bit and clock.
	assign incHigh0 = split0 & control_r[`CTL_T1_RUN] & tick1;

	always @* begin
		step0 = stepTimer(modeT0[1:0], low0_r, high0_r, inc0);
		step1 = stepTimer(modeT1[1:0], low1_r, high1_r, inc1);
		high0Split = high0_r + {7'h00, incHigh0};
		high0Ovf = incHigh0 & (high0_r == 8'hff);
	end

	// Bus write path: address and data may arrive in either order.
	assign s_axi_awready = ~awHeld_r;
	assign s_axi_wready = ~wHeld_r;
	assign doWrite = awHeld_r & wHeld_r & ~s_axi_bvalid;
	assign wrIdx = regIndex(awAddr_r);
	assign wrEn = doWrite & wLane0_r & (awAddr_r[AW-1:10] == 0);

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= {AW{1'b0}};
			wData_r <= 8'h00;
			wLane0_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid & ~awHeld_r) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid & ~wHeld_r) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata[7:0];
				wLane0_r <= s_axi_wstrb[0];
			end
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (rdHitW(wrIdx) && (awAddr_r[AW-1:10] == 0)) ?
					`RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// True for every index that holds a register.
	function rdHitW;
		input [7:0] idx;
		begin
			case (idx)
				`IDX_CONTROL, `IDX_MODE, `IDX_LOW0, `IDX_LOW1, `IDX_HIGH0, `IDX_HIGH1,
				`IDX_CLKSEL, `IDX_IRQ_STAT, `IDX_IRQ_CLR, `IDX_IRQ_EN: rdHitW = 1'b1;
				default: rdHitW = 1'b0;
			endcase
		end
	endfunction

	// Read mux; the write-only clear register reads as zero.
	always @* begin
		rdHit = rdHitW(regIndex(s_axi_araddr)) & (s_axi_araddr[AW-1:10] == 0);
		case (regIndex(s_axi_araddr))
			`IDX_CONTROL: rdVal = control_r;
			`IDX_MODE: rdVal = mode_r;
			`IDX_LOW0: rdVal = low0_r;
			`IDX_LOW1: rdVal = low1_r;
			`IDX_HIGH0: rdVal = high0_r;
			`IDX_HIGH1: rdVal = high1_r;
			`IDX_CLKSEL: rdVal = {3'h0, clkSel_r, 3'h0};
			`IDX_IRQ_STAT: rdVal = {4'h0, irqStat_r};
			`IDX_IRQ_EN: rdVal = {4'h0, irqEn_r};
			default: rdVal = 8'h00;
		endcase
		if (!rdHit) begin
			rdVal = 8'h00;
		end
	end

	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid & ~s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rdVal};
			s_axi_rresp <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Control flags: software first, then vector clears, hardware sets last so they win.
	always @* begin
		control_nxt = control_r;
		if (wrEn && wrIdx == `IDX_CONTROL) begin
			control_nxt = wData_r;
		end
		if (t1VecAck) begin
			control_nxt[`CTL_T1_OVF] = 1'b0;
		end
		if (t0VecAck) begin
			control_nxt[`CTL_T0_OVF] = 1'b0;
		end
		if (ext1VecAck && control_r[`CTL_X1_TYPE]) begin
			control_nxt[`CTL_X1_DET] = 1'b0;
		end
		if (ext0VecAck && control_r[`CTL_X0_TYPE]) begin
			control_nxt[`CTL_X0_DET] = 1'b0;
		end
		if (step1[16] || high0Ovf) begin
			control_nxt[`CTL_T1_OVF] = 1'b1;
		end
		if (step0[16]) begin
			control_nxt[`CTL_T0_OVF] = 1'b1;
		end
		// Type bit set selects falling edge; clear selects low level.
		if (control_r[`CTL_X1_TYPE]) begin
			if (int1Fell) begin
				control_nxt[`CTL_X1_DET] = 1'b1;
			end
		end else begin
			control_nxt[`CTL_X1_DET] = ~int1Level;
		end
		if (control_r[`CTL_X0_TYPE]) begin
			if (int0Fell) begin
				control_nxt[`CTL_X0_DET] = 1'b1;
			end
		end else begin
			control_nxt[`CTL_X0_DET] = ~int0Level;
		end
	end

	assign irqEvent = {int1Fell, int0Fell, step1[16] | high0Ovf, step0[16]};

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			control_r <= `RST_CONTROL;
			mode_r <= `RST_MODE;
			clkSel_r <= 2'h0;
			low0_r <= 8'h00;
			high0_r <= 8'h00;
			low1_r <= 8'h00;
			high1_r <= 8'h00;
			irqStat_r <= `RST_IRQ;
			irqEn_r <= `RST_IRQ;
		end else begin
			control_r <= control_nxt;
			low0_r <= step0[7:0];
			high0_r <= split0 ? high0Split : step0[15:8];
			low1_r <= step1[7:0];
			high1_r <= step1[15:8];
			// A count byte written by software replaces this cycle's step.
			if (wrEn) begin
				case (wrIdx)
					`IDX_MODE: mode_r <= wData_r;
					`IDX_CLKSEL: clkSel_r <= {wData_r[`CLK_T1_DIV], wData_r[`CLK_T0_DIV]};
					`IDX_LOW0: low0_r <= wData_r;
					`IDX_HIGH0: high0_r <= wData_r;
					`IDX_LOW1: low1_r <= wData_r;
					`IDX_HIGH1: high1_r <= wData_r;
					`IDX_IRQ_EN: irqEn_r <= wData_r[3:0];
					default: begin
					end
				endcase
			end
			// Status is sticky; a new event in the clearing cycle survives.
			irqStat_r <= (irqStat_r & ~((wrEn && wrIdx == `IDX_IRQ_CLR) ?
				wData_r[3:0] : 4'h0)) | irqEvent;
		end
	end

	assign t0OverflowFlag = control_r[`CTL_T0_OVF];
	assign t1OverflowFlag = control_r[`CTL_T1_OVF];
	assign extIrq0DetectFlag = control_r[`CTL_X0_DET];
	assign extIrq1DetectFlag = control_r[`CTL_X1_DET];
	assign irq = |(irqStat_r & irqEn_r);
endmodule // dual_timer

// ---- verilog/dual_timer_map.vh ----
// Register indexes, field positions, reset values and timing counts of the dual timer.
`ifndef DUAL_TIMER_MAP_VH
`define DUAL_TIMER_MAP_VH

// Register indexes; the bus byte address is four times the index.
`define IDX_CONTROL 8'h88
`define IDX_MODE 8'h89
`define IDX_LOW0 8'h8a
`define IDX_LOW1 8'h8b
`define IDX_HIGH0 8'h8c
`define IDX_HIGH1 8'h8d
`define IDX_CLKSEL 8'h8e
`define IDX_IRQ_STAT 8'ha0
`define IDX_IRQ_CLR 8'ha1
`define IDX_IRQ_EN 8'ha2

// Timer control register fields.
`define CTL_T1_OVF 7
`define CTL_T1_RUN 6
`define CTL_T0_OVF 5
`define CTL_T0_RUN 4
`define CTL_X1_DET 3
`define CTL_X1_TYPE 2
`define CTL_X0_DET 1
`define CTL_X0_TYPE 0

// Timer mode register: timer 1 in the upper nibble, timer 0 in the lower.
`define MODE_T1_LSB 4
`define MODE_GATE 3
`define MODE_SRC 2
`define MODE_SEL_HI 1
`define MODE_SEL_LO 0

// Operating modes.
`define OPMODE_PRESCALE 2'h0
`define OPMODE_FULL 2'h1
`define OPMODE_RELOAD 2'h2
`define OPMODE_SPLIT 2'h3

// Clock select register fields.
`define CLK_T1_DIV 4
`define CLK_T0_DIV 3

// Interrupt status, clear and enable bit positions.
`define IRQ_T0_OVF 0
`define IRQ_T1_OVF 1
`define IRQ_X0_DET 2
`define IRQ_X1_DET 3

// Reset values.
`define RST_CONTROL 8'h00
`define RST_MODE 8'h00
`define RST_CLKSEL 8'h00
`define RST_IRQ 4'h0

// Internal timer clock divide ratios.
`define DIV_FAST 4
`define DIV_SLOW 12

// Bus response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- verilog/pin_sync.v ----
// Three-stage synchroniser with agreement filter and falling-edge pulse.
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Pin and result
	input wire pinIn,
	output reg level_r,
	output reg fell_r
);
	reg s1_r;
	reg s2_r;
	reg s3_r;

	// A change counts only when the second and third stages agree.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			level_r <= 1'b1;
			fell_r <= 1'b0;
		end else begin
			s1_r <= pinIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
			fell_r <= 1'b0;
			if (s2_r == s3_r) begin
				level_r <= s3_r;
				fell_r <= level_r & ~s3_r;
			end
		end
	end
endmodule // pin_sync

// ---- verilog/tick_div.v ----
// Internal timer tick generator dividing the core clock by 4 or by 12.
`timescale 1ns/1ps
`include "dual_timer_map.vh"
module tick_div #(
	parameter [3:0] FAST = `DIV_FAST,
	parameter [3:0] SLOW = `DIV_SLOW
) (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Divide select and tick
	input wire divFast,
	output reg tick_r
);
	reg [3:0] count_r;

	// A changed ratio takes effect at the next reload, so no runt tick appears.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			count_r <= 4'h0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (count_r == 4'h0);
			if (count_r == 4'h0) begin
				count_r <= (divFast ? FAST : SLOW) - 4'h1;
			end else begin
				count_r <= count_r - 4'h1;
			end
		end
	end
endmodule // tick_div
